//--- mhc_top.sv
// modulator high-carrier source select, conditioning and sync gating
//
// Functional notes
// - bit 7 set blocks carrier from pin
// - bit 6 set inverts selected carrier
// - bit 5 delays low switch to falling edge
// - sync off: switch immediately, glitches allowed
// - bit 4 reads zero, writes ignored
// - code 0111 routes fourth pwm channel
// - code 1111 connects nothing, carrier low
// - implemented bits read and write freely
`timescale 1ns/1ns

module mhc_top (
  input  wire logic                               core_clk_i,    // system clock
  input  wire logic                               sys_rst_i,     // async reset, high
  // register port
  input  wire logic [mhc_pkg::MHC_ADDR_W-1:0]     reg_addr_i,    // register address
  input  wire logic [mhc_pkg::MHC_DATA_W-1:0]     reg_wdata_i,   // write data
  input  wire logic                               reg_wr_i,      // write strobe
  input  wire logic                               reg_rd_i,      // read strobe
  output logic      [mhc_pkg::MHC_DATA_W-1:0]     reg_rdata_o,   // read data, next cycle
  // carrier sources
  input  wire mhc_pkg::mhc_src_t                  src_i,         // async carrier sources
  // modulator side
  input  wire logic                               mod_want_hi_i, // modulation wants high carrier
  output logic                                    hi_carrier_o,  // conditioned carrier to mixer
  output logic                                    hi_active_o,   // high carrier path selected
  output logic                                    pin_out_o,     // peripheral pin level
  output logic                                    pin_oe_o       // peripheral pin drive enable
);

  // ==========================================================================
  // helper functions
  // ==========================================================================
  // pick one source by code; unmapped and reserved codes give low
  function automatic logic sel_src(input logic [3:0] code, input mhc_pkg::mhc_src_t s);
    logic r;
    r = 1'b0;
    case (code)
      mhc_pkg::MHC_SRC_LOW:    r = 1'b0;
      mhc_pkg::MHC_SRC_PIN1:   r = s.ext_pin1;
      mhc_pkg::MHC_SRC_PIN2:   r = s.ext_pin2;
      mhc_pkg::MHC_SRC_REFCLK: r = s.ref_clk;
      mhc_pkg::MHC_SRC_PWM1:   r = s.pwm_channel_one;
      mhc_pkg::MHC_SRC_PWM2:   r = s.pwm_channel_two;
      mhc_pkg::MHC_SRC_PWM3:   r = s.pwm_channel_three;
      mhc_pkg::MHC_SRC_PWM4:   r = s.pwm_channel_four;
      mhc_pkg::MHC_SRC_RSVD:   r = 1'b0;
      default:                 r = 1'b0;
    endcase
    return r;
  endfunction : sel_src

  // ==========================================================================
  // control register
  // ==========================================================================
  logic [mhc_pkg::MHC_DATA_W-1:0] ctrl_q;         // stored control bits
  mhc_pkg::mhc_ctrl_t             ctrl;           // decoded view

  assign ctrl.hi_carrier_out_disable   = ctrl_q[mhc_pkg::MHC_BIT_OUT_DIS];
  assign ctrl.hi_carrier_invert        = ctrl_q[mhc_pkg::MHC_BIT_INVERT];
  assign ctrl.hi_carrier_sync_enable   = ctrl_q[mhc_pkg::MHC_BIT_SYNC];
  assign ctrl.hi_carrier_source_select = ctrl_q[mhc_pkg::MHC_SEL_MSB:mhc_pkg::MHC_SEL_LSB];

  // write path; bit 4 is masked so it never stores
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q <= mhc_pkg::MHC_CTRL_RST;
    end else if (reg_wr_i && (reg_addr_i == mhc_pkg::MHC_ADDR_CTRL)) begin
      ctrl_q <= reg_wdata_i & mhc_pkg::MHC_CTRL_IMPL_MASK;
    end
  end

  // ==========================================================================
  // source synchronisers
  // ==========================================================================
  // sources may come from pins or other clocks, so two flops before use
  mhc_pkg::mhc_src_t src_meta_q;                  // first stage, read only by second
  mhc_pkg::mhc_src_t src_sync_q;                  // second stage, safe to use
  logic              want_meta_q;                 // modulation request first stage
  logic              want_sync_q;                 // modulation request second stage

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_meta_q  <= '0;
      src_sync_q  <= '0;
      want_meta_q <= 1'b0;
      want_sync_q <= 1'b0;
    end else begin
      src_meta_q  <= src_i;
      src_sync_q  <= src_meta_q;
      want_meta_q <= mod_want_hi_i;
      want_sync_q <= want_meta_q;
    end
  end

  // ==========================================================================
  // select and invert
  // ==========================================================================
  logic sel_raw;                                  // chosen source, not inverted
  logic carrier_d;                                // conditioned carrier
  logic carrier_q;                                // registered carrier

  assign sel_raw   = sel_src(ctrl.hi_carrier_source_select, src_sync_q);
  // reserved code stays inactive even with inversion on, so it is gated here
  assign carrier_d = (ctrl.hi_carrier_source_select == mhc_pkg::MHC_SRC_RSVD) ? 1'b0 :
                     (sel_raw ^ ctrl.hi_carrier_invert);

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      carrier_q <= 1'b0;
    end else begin
      carrier_q <= carrier_d;
    end
  end

  // ==========================================================================
  // sync gating of the switch to the low carrier
  // ==========================================================================
  logic fall_edge;                                // conditioned carrier falls
  logic active_q;                                 // high path currently selected
  logic active_d;                                 // next selection

  assign fall_edge = carrier_q & ~carrier_d;

  // entering the high carrier is immediate; leaving it may wait for a falling edge
  always_comb begin
    active_d = active_q;
    if (want_sync_q) begin
      active_d = 1'b1;
    end else if (!ctrl.hi_carrier_sync_enable) begin
      active_d = 1'b0;
    end else if (fall_edge || !carrier_q) begin
      // carrier already low counts as past its edge, so no stall on a dead source
      active_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_d;
    end
  end

  // ==========================================================================
  // outputs, all registered
  // ==========================================================================
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hi_carrier_o <= 1'b0;
      hi_active_o  <= 1'b0;
      pin_out_o    <= 1'b0;
      pin_oe_o     <= 1'b0;
    end else begin
      hi_carrier_o <= carrier_d;
      hi_active_o  <= active_d;
      pin_out_o    <= ctrl.hi_carrier_out_disable ? 1'b0 : carrier_d;
      pin_oe_o     <= ~ctrl.hi_carrier_out_disable;
    end
  end

  // ==========================================================================
  // read path
  // ==========================================================================
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        mhc_pkg::MHC_ADDR_CTRL:   reg_rdata_o <= ctrl_q & mhc_pkg::MHC_CTRL_IMPL_MASK;
        mhc_pkg::MHC_ADDR_STATUS: reg_rdata_o <= {6'h00, active_q, carrier_q};
        default:                  reg_rdata_o <= '0;  // unmapped reads zero
      endcase
    end else begin
      reg_rdata_o <= '0;                          // data valid one cycle only
    end
  end

endmodule : mhc_top

//--- mhc_pkg.sv
// package for the modulator high-carrier select block: register layout and source codes
package mhc_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [3:0] MHC_ADDR_CTRL   = 4'h0;     // high_carrier_control word
  localparam logic [3:0] MHC_ADDR_STATUS = 4'h1;     // live carrier state (read only)
  localparam int         MHC_ADDR_W      = 4;        // register address width
  localparam int         MHC_DATA_W      = 8;        // register data width

  // ==========================================================================
  // control register field positions
  // ==========================================================================
  localparam int MHC_BIT_OUT_DIS = 7;                // output disable
  localparam int MHC_BIT_INVERT  = 6;                // polarity
  localparam int MHC_BIT_SYNC    = 5;                // sync to falling edge
  localparam int MHC_BIT_UNUSED  = 4;                // unimplemented, reads zero
  localparam int MHC_SEL_MSB     = 3;                // selection field top
  localparam int MHC_SEL_LSB     = 0;                // selection field bottom

  // mask of the bits that store a value
  localparam logic [7:0] MHC_CTRL_IMPL_MASK = 8'hEF;
  // value taken under reset (the real part powers up unknown)
  localparam logic [7:0] MHC_CTRL_RST       = 8'h00;

  // ==========================================================================
  // source selection codes
  // ==========================================================================
  localparam logic [3:0] MHC_SRC_LOW     = 4'h0;     // constant low
  localparam logic [3:0] MHC_SRC_PIN1    = 4'h1;     // first external carrier pin
  localparam logic [3:0] MHC_SRC_PIN2    = 4'h2;     // second external carrier pin
  localparam logic [3:0] MHC_SRC_REFCLK  = 4'h3;     // reference clock
  localparam logic [3:0] MHC_SRC_PWM1    = 4'h4;     // first pwm channel
  localparam logic [3:0] MHC_SRC_PWM2    = 4'h5;     // second pwm channel
  localparam logic [3:0] MHC_SRC_PWM3    = 4'h6;     // third pwm channel
  localparam logic [3:0] MHC_SRC_PWM4    = 4'h7;     // pwm_channel_four
  localparam logic [3:0] MHC_SRC_RSVD    = 4'hF;     // reserved, nothing connected

  // ==========================================================================
  // carrier sources bundled together
  // ==========================================================================
  typedef struct packed {
    logic pwm_channel_four;                          // fourth pwm output
    logic pwm_channel_three;                         // third pwm output
    logic pwm_channel_two;                           // second pwm output
    logic pwm_channel_one;                           // first pwm output
    logic ref_clk;                                   // reference clock signal
    logic ext_pin2;                                  // second carrier input pin
    logic ext_pin1;                                  // first carrier input pin
  } mhc_src_t;

  // control register decoded into fields
  typedef struct packed {
    logic       hi_carrier_out_disable;              // block the pin copy
    logic       hi_carrier_invert;                   // invert selected carrier
    logic       hi_carrier_sync_enable;              // hold switch to falling edge
    logic [3:0] hi_carrier_source_select;            // source code
  } mhc_ctrl_t;

endpackage : mhc_pkg

//--- mhc_checker.sv
// assertion checker for the high-carrier select block
`timescale 1ns/1ns
module mhc_checker (
  input  wire logic                           core_clk_i,
  input  wire logic                           sys_rst_i,
  input  wire logic [mhc_pkg::MHC_ADDR_W-1:0] reg_addr_i,
  input  wire logic [mhc_pkg::MHC_DATA_W-1:0] reg_wdata_i,
  input  wire logic                           reg_wr_i,
  input  wire logic                           reg_rd_i,
  input  wire logic [mhc_pkg::MHC_DATA_W-1:0] reg_rdata_o,
  input  wire mhc_pkg::mhc_src_t              src_i,
  input  wire logic                           mod_want_hi_i,
  input  wire logic                           hi_carrier_o,
  input  wire logic                           hi_active_o,
  input  wire logic                           pin_out_o,
  input  wire logic                           pin_oe_o
);
  logic [7:0] ctl_q; // shadow of the control word
  logic [2:0] age_q; // cycles since the shadow changed, saturates so it never wraps
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================================
  // shadow of the control word and its age
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) ctl_q <= 8'h00;
    else if (reg_wr_i && reg_addr_i == 4'h0) ctl_q <= reg_wdata_i;
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) age_q <= 3'h0;
    else if (reg_wr_i && reg_addr_i == 4'h0 && reg_wdata_i != ctl_q) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end
  // ==========================================================================
  // assertions
  chk_oe_follow: assert property (age_q >= 3'h2 |-> pin_oe_o == !ctl_q[7])
    else $error("pin enable disagrees with disable bit");
  chk_pin_quiet: assert property (!pin_oe_o |-> !pin_out_o)
    else $error("disabled pin still carries the carrier");
  chk_pin_copy: assert property (age_q >= 3'h2 && pin_oe_o |-> pin_out_o == hi_carrier_o)
    else $error("enabled pin differs from carrier");
  chk_pwm4_path: assert property (age_q >= 3'h4 && ctl_q[3:0] == 4'h7 |->
    hi_carrier_o == ($past(src_i.pwm_channel_four, 3) ^ ctl_q[6]))
    else $error("fourth pwm channel not routed");
  chk_rsvd_low: assert property (age_q >= 3'h2 && ctl_q[3:0] == 4'hF |-> !hi_carrier_o)
    else $error("reserved code drives the carrier");
  chk_active_rise: assert property ($past(mod_want_hi_i, 3) |-> hi_active_o)
    else $error("high path not taken three edges after request");
  chk_nosync_drop: assert property (age_q >= 3'h4 && !ctl_q[5] && !$past(mod_want_hi_i, 3)
    |-> !hi_active_o)
    else $error("unsynchronised switch delayed");
  chk_sync_hold: assert property (age_q >= 3'h4 && ctl_q[5] && $past(hi_active_o)
    && $past(hi_carrier_o) && hi_carrier_o |-> hi_active_o)
    else $error("high path left before a falling carrier edge");
  chk_rd_bit4: assert property (reg_rd_i |=> !reg_rdata_o[4])
    else $error("unimplemented bit read as one");
  chk_wr_rd: assert property (reg_wr_i && reg_addr_i == 4'h0 ##1 reg_rd_i && reg_addr_i == 4'h0
    |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'hEF))
    else $error("control word read back wrong");
endmodule : mhc_checker
bind mhc_top mhc_checker mhc_checker_inst (.*);

//--- mhc_src_model.sv
// far-side model: carrier sources, with a running pwm on the fourth channel
`timescale 1ns/1ns
module mhc_src_model (
  input  wire logic              core_clk_i, // system clock
  input  wire logic              sys_rst_i,  // async reset, high
  input  wire logic              run_i,      // fourth channel in pwm output mode
  input  wire mhc_pkg::mhc_src_t lvl_i,      // static levels from the bench
  output mhc_pkg::mhc_src_t      src_o       // levels seen by the block
);
  logic [2:0] cnt_q; // half-period counter
  logic       pwm_q; // pwm level, eight cycles high then eight low
  // ==========================================================================
  // pwm runs only in pwm output mode; otherwise the static level stands
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= 3'h0;
      pwm_q <= 1'b0;
    end else if (run_i) begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == 3'h7) pwm_q <= ~pwm_q;
    end
  end
  assign src_o = run_i ? mhc_pkg::mhc_src_t'({pwm_q, lvl_i[5:0]}) : lvl_i;
endmodule : mhc_src_model

//--- testbench.sv
// self-checking bench for the high-carrier select block
`timescale 1ns/1ns
module testbench;
  logic              core_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, mod_want_hi_i, run;
  logic [3:0]        reg_addr_i;
  logic [7:0]        reg_wdata_i, reg_rdata_o;
  logic              hi_carrier_o, hi_active_o, pin_out_o, pin_oe_o;
  mhc_pkg::mhc_src_t src_i, lvl;
  int                error_cnt, checks, i;
  // rows: control word, source levels, expected {carrier, pin, enable}
  logic [7:0] t_ctl [16] = '{8'h07, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01,
                             8'h01, 8'h00, 8'h40, 8'h0F, 8'h4F, 8'h48, 8'h87, 8'h57};
  logic [6:0] t_src [16] = '{7'h40, 7'h3F, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01,
                             7'h7E, 7'h7F, 7'h00, 7'h7F, 7'h7F, 7'h00, 7'h40, 7'h40};
  logic [2:0] t_exp [16] = '{3'h7, 3'h1, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7,
                             3'h1, 3'h1, 3'h7, 3'h1, 3'h1, 3'h7, 3'h4, 3'h1};
  mhc_top mhc_top_inst (.*);
  mhc_src_model mhc_src_model_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
                                    .run_i(run), .lvl_i(lvl), .src_o(src_i));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // ==========================================================================
  // shared tasks; bus tasks start and end just after a rising edge
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b0;
    #1 chk(reg_rdata_o, exp);
    @(posedge core_clk_i);
  endtask : rd
  task automatic results;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // ==========================================================================
  // main sequence
  initial begin
    {sys_rst_i, reg_wr_i, reg_rd_i, mod_want_hi_i, run} = 5'h10;
    {reg_addr_i, reg_wdata_i, lvl, error_cnt, checks} = '0;
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rd(4'h0, 8'h00);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'hEF);
    wr(4'h2, 8'h00);
    rd(4'h0, 8'hEF);
    rd(4'h9, 8'h00);
    $display("register test done");
    for (i = 0; i < 16; i++) begin
      lvl <= t_src[i];
      wr(4'h0, t_ctl[i]);
      repeat (6) @(posedge core_clk_i);
      #1 chk({5'h00, hi_carrier_o, pin_out_o, pin_oe_o}, {5'h00, t_exp[i]});
      @(posedge core_clk_i);
    end
    $display("source table test done");
    run <= 1'b1;
    for (i = 0; i < 2; i++) begin
      wr(4'h0, i ? 8'h27 : 8'h07);
      mod_want_hi_i <= 1'b1;
      repeat (20) @(posedge core_clk_i);
      while (hi_carrier_o !== 1'b0) @(posedge core_clk_i);
      while (hi_carrier_o !== 1'b1) @(posedge core_clk_i);
      mod_want_hi_i <= 1'b0;
      repeat (5) @(posedge core_clk_i);
      #1 chk({7'h00, hi_active_o}, {7'h00, i[0]});
      while (hi_carrier_o !== 1'b0) @(posedge core_clk_i);
      @(posedge core_clk_i);
      #1 chk({7'h00, hi_active_o}, 8'h00);
      @(posedge core_clk_i);
    end
    $display("sync test done");
    // status word: code 0 inverted gives a steady high carrier, request held high
    wr(4'h0, 8'h40);
    mod_want_hi_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    rd(4'h1, 8'h03);
    // drop the request well before reset so no stale request spans the release
    mod_want_hi_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    @(posedge core_clk_i);
    #1 chk({4'h0, hi_carrier_o, hi_active_o, pin_out_o, pin_oe_o}, 8'h00);
    @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rd(4'h0, 8'h00);
    $display("reset test done");
    results();
  end
  initial begin
    #200000;
    error_cnt++;
    results();
  end
endmodule : testbench
